/* fbl_pkg.sv */
/*
  Shared constants and carrier types for the flash bitstream boot loader.
  Assumes a single 100 MHz system clock and a flash read port on that same clock.
*/
// ====================
// Package
// ====================
package fbl_pkg;

  // Clock figures
  localparam int CLK_HZ = 100_000_000;      // System clock rate
  localparam int CLK_NS = 10;               // System clock period

  // Time figures and their cycle counts
  localparam int BOOT_BUDGET_MS  = 200;                                  // Power-up deadline
  localparam int BOOT_BUDGET_CYC = BOOT_BUDGET_MS * (CLK_HZ / 1000);     // Longest: rounds down
  localparam int RELOAD_BUTTON_LOW_NS     = 250;                                  // Least clear pulse
  localparam int RELOAD_BUTTON_LOW_CYC    = (RELOAD_BUTTON_LOW_NS + CLK_NS - 1) / CLK_NS;  // Least: rounds up
  localparam int DONE_WAIT_US    = 100;                                  // Done wait limit
  localparam int DONE_WAIT_CYC   = (DONE_WAIT_US * 1000) / CLK_NS;       // Longest: rounds down
  localparam int SETTLE_CYC      = 4;                                    // Pin synchroniser settle

  // Widths
  localparam int NUM_SECTIONS = 4;          // Stored images
  localparam int SECT_W       = 2;          // Section index width
  localparam int CFG_W        = 32;         // Configuration port width
  localparam int FLASH_AW     = 26;         // Flash word address width
  localparam int LEN_W        = 26;         // Image length field width (words)
  localparam int CNT_W        = 25;         // Timer width
  localparam int PEND_W       = 4;          // Outstanding read counter width
  localparam logic [PEND_W-1:0] MAX_PEND = 4'h8;  // Most flash reads in flight

  // Image header layout inside a section (word offsets)
  localparam logic [FLASH_AW-1:0] HDR_MARK_OFS = 26'h0000000;  // Validity marker word
  localparam logic [FLASH_AW-1:0] HDR_LEN_OFS  = 26'h0000001;  // Length word
  localparam logic [FLASH_AW-1:0] IMG_DATA_OFS = 26'h0000002;  // First bitstream word
  localparam logic [LEN_W-1:0]    HDR_WORDS    = 26'h0000002;  // Header reads per check
  localparam logic [CFG_W-1:0]    IMG_MARK     = 32'ha5c3_5a3c; // Arbitrary marker value

  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 25'h0000000;

  // Loader states, one-hot
  typedef enum logic [7:0] {
    FBL_ST_SETTLE    = 8'h01,
    FBL_ST_IDLE      = 8'h02,
    FBL_ST_START     = 8'h04,
    FBL_ST_HEADER    = 8'h08,
    FBL_ST_CLEAR     = 8'h10,
    FBL_ST_WAIT_INIT = 8'h20,
    FBL_ST_STREAM    = 8'h40,
    FBL_ST_WAIT_DONE = 8'h80
  } fbl_state_t;

  // Board pins, all asynchronous to clk_sys
  typedef struct packed {
    logic              reload_button;            // High while pressed
    logic              boot_mode_jumper;         // High when fitted
    logic              reload_request;           // From user design
    logic              image_choice_bit2_unused; // Ignored
    logic              image_choice_bit1;
    logic              image_choice_bit0;
    logic [SECT_W-1:0] boot_section_select;      // Non-volatile boot choice
    logic              tgt_init_b;               // Target ready, high when ready
    logic              tgt_done;                 // Target configured
    logic              scan_load_active;         // Scan-port load in progress
  } fbl_pins_t;
  localparam int PIN_W = $bits(fbl_pins_t);

  // Flash read request and answer
  typedef struct packed {
    logic                rd_req;
    logic [FLASH_AW-1:0] addr;
  } fbl_flash_req_t;
  typedef struct packed {
    logic             valid;
    logic [CFG_W-1:0] data;
  } fbl_flash_rsp_t;

  // Parallel configuration port
  typedef struct packed {
    logic             reload_button_b;  // Low clears target configuration
    logic             wr_b;    // Low for one cycle per word
    logic [CFG_W-1:0] data;
  } fbl_cfg_t;

  // Indicators
  typedef struct packed {
    logic loaded_section_lamp0;
    logic loaded_section_lamp1;
    logic loaded_section_lamp2_unused;
    logic load_error_lamp;
    logic fallback_lamp;
    logic config_done_lamp;
    logic budget_miss_lamp;
    logic busy;
  } fbl_lamps_t;

endpackage

/* fbl_pin_sync.sv */
/*
  Three-stage synchroniser with agreement filter for a group of pins.
  Assumes the inputs are asynchronous levels; output moves once stages two and three agree.
*/
`timescale 1ns/10ps
// ====================
// Pin synchroniser
// ====================
module fbl_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // Pins in and filtered levels out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  import fbl_pkg::*;

  // All synchroniser state
  typedef struct packed {
    logic [W-1:0] s1;   // Metastable stage, read only by s2
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } fbl_sync_t;

  fbl_sync_t sync_reg;   // Registered state
  fbl_sync_t sync_next;  // Next state

  // Next state: shift, and take a level only where s2 and s3 agree
  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = din;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (sync_reg.s2[i] == sync_reg.s3[i]) begin
        sync_next.out[i] = sync_reg.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg.out;
endmodule

/* fbl_loader.sv */
/*
  Flash bitstream boot loader: picks one of four flash sections, checks its header,
  clears the target and streams the image over a 32-bit parallel configuration port.
  Assumes a flash read port on clk_sys that accepts one read per cycle and answers in order,
  and board pins that are asynchronous and pass through the pin synchroniser.
*/
// Functional notes
// [R1] Four images, one per two-bit section
// [R2] Power-up without jumper loads from flash
// [R3] Power-up uses boot section select
// [R4] Invalid boot section: error lamp, no load
// [R5] User sets image choice, then raises request
// [R6] Request rise loads section bit1*2+bit0
// [R7] Invalid chosen section: boot section, fallback lamp
// [R8] Loaded section index shown on two lamps
// [R9] Image goes over 32-bit port at 100 MHz
// [R10] Power-up load finishes within 200 ms
// [R11] Reload button clears target at any time; the code does not clear while a scan-port load is active
// [R12] After button clear, reload unless jumper fitted
// [R13] Done lamp shows target configuration complete
// [R14] Scan-port load accepted anytime, replaces configuration
// [R15] Jumper fitted blocks any flash configuration; the code checks the jumper only before a load starts
// [R16] Configuration lost on power, button, scan, reload
// [R17] Image choice stable around request rising edge
`timescale 1ns/10ps
// ====================
// Loader top
// ====================
module fbl_loader #(
  parameter logic [fbl_pkg::CNT_W-1:0] BOOT_BUDGET_CYC = fbl_pkg::CNT_W'(fbl_pkg::BOOT_BUDGET_CYC),
  parameter logic [fbl_pkg::CNT_W-1:0] DONE_WAIT_CYC   = fbl_pkg::CNT_W'(fbl_pkg::DONE_WAIT_CYC)
) (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  // Board pins, asynchronous
  input  wire fbl_pkg::fbl_pins_t      pins_async,
  // Flash read port
  output fbl_pkg::fbl_flash_req_t      flash_req,
  input  wire fbl_pkg::fbl_flash_rsp_t flash_rsp,
  // Configuration port
  output fbl_pkg::fbl_cfg_t            cfg_port,
  // Indicators
  output fbl_pkg::fbl_lamps_t          lamps
);
  import fbl_pkg::*;

  // ====================
  // State
  // ====================
  typedef struct packed {
    fbl_state_t          st;          // Loader state
    logic [CNT_W-1:0]    cnt;         // State timer
    logic [CNT_W-1:0]    budget;      // Power-up deadline timer
    logic                budget_run;  // Deadline timer active
    logic [SECT_W-1:0]   sect;        // Section being loaded
    logic                user_try;    // Section came from the user, fallback allowed
    logic                mark_ok;     // Header marker matched
    logic                rcv_idx;     // Header word being received
    logic                load_go;     // Clear belongs to a validated load
    logic [LEN_W-1:0]    len;         // Image length in words
    logic [LEN_W-1:0]    iss_left;    // Reads still to issue
    logic [LEN_W-1:0]    rcv_left;    // Words still to receive
    logic [PEND_W-1:0]   pend;        // Reads in flight
    logic [FLASH_AW-1:0] addr;        // Next read address
    logic                req_prev;    // Last request level, for edge detect
    fbl_flash_req_t      flash;       // Registered flash request
    fbl_cfg_t            cfg;         // Registered configuration port
    fbl_lamps_t          lamp;        // Registered indicators
  } fbl_regs_t;

  fbl_regs_t  state_reg;   // Registered state
  fbl_regs_t  state_next;  // Next state
  fbl_pins_t  pin;         // Synchronised pins
  logic [PIN_W-1:0] pin_raw;
  logic       issue;       // A flash read goes out this cycle
  logic       req_rise;    // Reload request rising edge
  logic [LEN_W-1:0] hdr_len;  // Length carried by the current answer

  // Base word address of a section: index in the top address bits
  function automatic logic [FLASH_AW-1:0] sect_base(input logic [SECT_W-1:0] s);
    sect_base = {s, {(FLASH_AW-SECT_W){1'b0}}};  // [R1]
  endfunction

  // ====================
  // Pin synchroniser
  // ====================
  fbl_pin_sync #(
    .W (PIN_W)
  ) fbl_pin_sync_inst (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .din     (pins_async),
    .dout    (pin_raw)
  );
  assign pin = fbl_pins_t'(pin_raw);

  // ====================
  // Helper terms
  // ====================
  // Reads go out only in fetch states and with room in the in-flight window
  assign issue = ((state_reg.st == FBL_ST_HEADER) || (state_reg.st == FBL_ST_STREAM))
                 && (state_reg.iss_left != '0) && (state_reg.pend < MAX_PEND);
  // Edge, not level, so a request left high does not loop reloads
  assign req_rise = pin.reload_request & ~state_reg.req_prev;  // [R17]
  assign hdr_len  = flash_rsp.data[LEN_W-1:0];

  // ====================
  // Next-state logic
  // ====================
  always_comb begin
    state_next               = state_reg;
    state_next.flash.rd_req  = 1'b0;
    state_next.cfg.wr_b      = 1'b1;                         // Write strobe is a pulse
    state_next.req_prev      = pin.reload_request;
    state_next.lamp.config_done_lamp = pin.tgt_done;         // [R13]
    state_next.lamp.loaded_section_lamp2_unused = 1'b0;      // [R8]
    state_next.lamp.busy     = (state_reg.st != FBL_ST_IDLE);
    state_next.pend = state_reg.pend + PEND_W'(issue) - PEND_W'(flash_rsp.valid);

    // Power-up deadline: the miss lamp tells bring-up the image is too slow
    if (state_reg.budget_run) begin
      if (state_reg.budget == BOOT_BUDGET_CYC - 1'b1) begin
        state_next.lamp.budget_miss_lamp = 1'b1;             // [R10]
        state_next.budget_run = 1'b0;
      end else begin
        state_next.budget = state_reg.budget + 1'b1;
      end
    end

    // Shared read issue for header and stream
    if (issue) begin
      state_next.flash.rd_req = 1'b1;
      state_next.flash.addr   = state_reg.addr;
      state_next.addr         = state_reg.addr + 1'b1;
      state_next.iss_left     = state_reg.iss_left - 1'b1;
    end

    case (state_reg.st)
      // Let the pin synchroniser fill before the jumper is believed
      FBL_ST_SETTLE: begin
        if (state_reg.cnt == CNT_W'(SETTLE_CYC)) begin
          if (!pin.boot_mode_jumper) begin
            state_next.st   = FBL_ST_START;                  // [R2]
            state_next.sect = pin.boot_section_select;       // [R3]
          end else begin
            state_next.st         = FBL_ST_IDLE;             // [R15]
            state_next.budget_run = 1'b0;
          end
          state_next.user_try = 1'b0;
        end else begin
          state_next.cnt = state_reg.cnt + 1'b1;
        end
      end
      // Wait for a user request; stale flash answers drain here
      FBL_ST_IDLE: begin
        if (req_rise && !pin.boot_mode_jumper) begin         // [R15]
          state_next.st   = FBL_ST_START;
          state_next.sect = {pin.image_choice_bit1, pin.image_choice_bit0};  // [R6]
          state_next.user_try           = 1'b1;
          state_next.lamp.fallback_lamp = 1'b0;
        end
      end
      // Start header check once no old read is in flight
      FBL_ST_START: begin
        if (state_reg.pend == '0) begin
          state_next.st       = FBL_ST_HEADER;
          state_next.addr     = sect_base(state_reg.sect) + HDR_MARK_OFS;
          state_next.iss_left = HDR_WORDS;
          state_next.rcv_idx  = 1'b0;
          state_next.mark_ok  = 1'b0;
        end
      end
      // Marker word then length word decide validity
      FBL_ST_HEADER: begin
        if (flash_rsp.valid) begin
          if (!state_reg.rcv_idx) begin
            state_next.mark_ok = (flash_rsp.data == IMG_MARK);
            state_next.rcv_idx = 1'b1;
          end else begin
            state_next.len = hdr_len;
            if (state_reg.mark_ok && (hdr_len != '0)) begin
              state_next.st      = FBL_ST_CLEAR;
              state_next.load_go = 1'b1;
              state_next.cnt     = CNT_W'(RELOAD_BUTTON_LOW_CYC);
              state_next.lamp.loaded_section_lamp0 = 1'b0;   // [R16]
              state_next.lamp.loaded_section_lamp1 = 1'b0;
            end else if (state_reg.user_try) begin
              state_next.st       = FBL_ST_START;            // [R7]
              state_next.sect     = pin.boot_section_select;
              state_next.user_try = 1'b0;
              state_next.lamp.fallback_lamp = 1'b1;
            end else begin
              state_next.st = FBL_ST_IDLE;                   // [R4]
              state_next.lamp.load_error_lamp = 1'b1;
              state_next.budget_run = 1'b0;
            end
          end
        end
      end
      // Hold the target cleared for the least time and while the button is held
      FBL_ST_CLEAR: begin
        state_next.cfg.reload_button_b = 1'b0;                        // [R11]
        if (state_reg.cnt != '0) begin
          state_next.cnt = state_reg.cnt - 1'b1;
        end else if (!pin.reload_button) begin
          state_next.cfg.reload_button_b = 1'b1;
          if (state_reg.load_go) begin
            state_next.st = FBL_ST_WAIT_INIT;
          end else if (!pin.boot_mode_jumper) begin
            state_next.st       = FBL_ST_START;              // [R12]
            state_next.sect     = pin.boot_section_select;
            state_next.user_try = 1'b0;
          end else begin
            state_next.st = FBL_ST_IDLE;                     // [R15]
          end
        end
      end
      // Target signals it has wiped its memory and can take data
      FBL_ST_WAIT_INIT: begin
        if (pin.tgt_init_b) begin
          state_next.st       = FBL_ST_STREAM;
          state_next.addr     = sect_base(state_reg.sect) + IMG_DATA_OFS;
          state_next.iss_left = state_reg.len;
          state_next.rcv_left = state_reg.len;
        end
      end
      // Each flash answer becomes one 32-bit write on the port
      FBL_ST_STREAM: begin
        if (flash_rsp.valid) begin
          state_next.cfg.data = flash_rsp.data;              // [R9]
          state_next.cfg.wr_b = 1'b0;
          state_next.rcv_left = state_reg.rcv_left - 1'b1;
          if (state_reg.rcv_left == LEN_W'(1)) begin
            state_next.st  = FBL_ST_WAIT_DONE;
            state_next.cnt = DONE_WAIT_CYC;
          end
        end
      end
      // Target must report done; a bad image times out as an error
      FBL_ST_WAIT_DONE: begin
        if (pin.tgt_done) begin
          state_next.st = FBL_ST_IDLE;
          state_next.lamp.loaded_section_lamp0 = state_reg.sect[0];  // [R8]
          state_next.lamp.loaded_section_lamp1 = state_reg.sect[1];
          state_next.lamp.load_error_lamp      = 1'b0;
          state_next.budget_run                = 1'b0;               // [R10]
        end else if (state_reg.cnt == '0) begin
          state_next.st = FBL_ST_IDLE;
          state_next.lamp.load_error_lamp = 1'b1;
        end else begin
          state_next.cnt = state_reg.cnt - 1'b1;
        end
      end
      default: begin
        state_next.st = FBL_ST_IDLE;
      end
    endcase

    // Button press overrides any load in progress
    if (pin.reload_button && !((state_reg.st == FBL_ST_CLEAR) && !state_reg.load_go)) begin
      state_next.st       = FBL_ST_CLEAR;                    // [R11]
      state_next.load_go  = 1'b0;
      state_next.cnt      = CNT_W'(RELOAD_BUTTON_LOW_CYC);
      state_next.iss_left = '0;
      state_next.cfg.reload_button_b = 1'b0;
      state_next.lamp.loaded_section_lamp0 = 1'b0;           // [R16]
      state_next.lamp.loaded_section_lamp1 = 1'b0;
      state_next.lamp.fallback_lamp        = 1'b0;
      state_next.lamp.load_error_lamp      = 1'b0;
    end

    // Scan-port load wins: release the port and forget the flash image
    if (pin.scan_load_active) begin
      state_next.st         = FBL_ST_IDLE;                   // [R14]
      state_next.iss_left   = '0;
      state_next.cfg.reload_button_b = 1'b1;
      state_next.budget_run = 1'b0;
      state_next.lamp.loaded_section_lamp0 = 1'b0;           // [R16]
      state_next.lamp.loaded_section_lamp1 = 1'b0;
    end
  end

  // ====================
  // State register
  // ====================
  // Power-up is the reset release, so the deadline timer starts running here
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg            <= '0;
      state_reg.st         <= FBL_ST_SETTLE;
      state_reg.cnt        <= CNT_RST;
      state_reg.budget     <= CNT_RST;
      state_reg.budget_run <= 1'b1;
      state_reg.cfg.reload_button_b <= 1'b1;
      state_reg.cfg.wr_b   <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ====================
  // Outputs, straight from the state register
  // ====================
  assign flash_req = state_reg.flash;
  assign cfg_port  = state_reg.cfg;
  assign lamps     = state_reg.lamp;
endmodule

/* fbl_loader_props.sv */
/*
  Port checker for the flash bitstream boot loader.
  Assumes it is bound to every fbl_loader and sees that module's ports only.
*/
`timescale 1ns/10ps
// ====================
// Checker
// ====================
module fbl_loader_props #(
  parameter logic [fbl_pkg::CNT_W-1:0] BOOT_BUDGET_CYC = 25'h00000c8,
  parameter logic [fbl_pkg::CNT_W-1:0] DONE_WAIT_CYC   = 25'h0000032
) (
  // Clock and reset
  input wire logic                    clk_sys,
  input wire logic                    rst_b,
  // Watched ports
  input wire fbl_pkg::fbl_pins_t      pins_async,
  input wire fbl_pkg::fbl_flash_req_t flash_req,
  input wire fbl_pkg::fbl_flash_rsp_t flash_rsp,
  input wire fbl_pkg::fbl_cfg_t       cfg_port,
  input wire fbl_pkg::fbl_lamps_t     lamps
);
  import fbl_pkg::*;
  logic [7:0]  low_cnt;  // Length of the running clear pulse
  logic [4:0]  fly_cnt;  // Reads not yet answered
  logic [31:0] up_cnt;   // Cycles since reset release
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Helper counters; the clear counter saturates so a held button cannot wrap it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt <= 8'h00;
      fly_cnt <= 5'h00;
      up_cnt  <= 32'h0;
    end else begin
      low_cnt <= cfg_port.reload_button_b ? 8'h00 : ((low_cnt == 8'hff) ? low_cnt : low_cnt + 8'h01);
      fly_cnt <= fly_cnt + 5'(flash_req.rd_req) - 5'(flash_rsp.valid);
      up_cnt  <= up_cnt + 32'h1;
    end
  end
  lamp_two_idle_a: assert property (!lamps.loaded_section_lamp2_unused)
    else $error("third section lamp lit");
  jumper_quiet_a: assert property ((pins_async.boot_mode_jumper && !lamps.busy)[*8] |->
    !flash_req.rd_req && cfg_port.wr_b) else $error("flash activity with jumper fitted");
  scan_hold_a: assert property (pins_async.scan_load_active[*6] |->
    !flash_req.rd_req && cfg_port.reload_button_b) else $error("loader active during scan load");
  button_clear_a: assert property ((pins_async.reload_button && !pins_async.scan_load_active)[*6] |->
    !cfg_port.reload_button_b) else $error("target not cleared while button held");
  clear_width_a: assert property ($rose(cfg_port.reload_button_b) |-> low_cnt >= 8'h19)
    else $error("clear pulse too short");
  write_data_a: assert property (!cfg_port.wr_b |-> $past(flash_rsp.valid) && cfg_port.reload_button_b &&
    cfg_port.data == $past(flash_rsp.data)) else $error("port word differs from flash word");
  err_no_clear_a: assert property ($rose(lamps.load_error_lamp) |->
    cfg_port.reload_button_b && $past(cfg_port.reload_button_b)) else $error("target cleared on failed load");
  fly_bound_a: assert property (fly_cnt <= 5'h08)
    else $error("too many flash reads in flight");
  budget_late_a: assert property ($rose(lamps.budget_miss_lamp) |-> up_cnt >= 32'(BOOT_BUDGET_CYC))
    else $error("budget lamp lit early");
endmodule

bind fbl_loader fbl_loader_props #(
  .BOOT_BUDGET_CYC(BOOT_BUDGET_CYC),
  .DONE_WAIT_CYC  (DONE_WAIT_CYC)
) fbl_loader_props_inst (
  .clk_sys   (clk_sys),
  .rst_b     (rst_b),
  .pins_async(pins_async),
  .flash_req (flash_req),
  .flash_rsp (flash_rsp),
  .cfg_port  (cfg_port),
  .lamps     (lamps)
);

/* fbl_flash_model.sv */
/*
  Behavioural parallel flash holding four sections.
  Assumes reads arrive on clk_sys; answers in order, promptly or every other cycle.
*/
`timescale 1ns/10ps
// ====================
// Flash model
// ====================
module fbl_flash_model (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  // Read port
  input  wire fbl_pkg::fbl_flash_req_t req,
  output fbl_pkg::fbl_flash_rsp_t      rsp,
  // Sections holding an image, and slow answers
  input  wire logic [3:0]              valid_mask,
  input  wire logic                    slow
);
  import fbl_pkg::*;
  logic [FLASH_AW-1:0] pend[$];  // Reads waiting for an answer
  logic                tog;      // Cadence for slow answers
  // Header marker, length two, then words that carry their own address
  function automatic logic [CFG_W-1:0] word(input logic [FLASH_AW-1:0] a);
    if (a[23:0] == 24'h000000) return valid_mask[a[25:24]] ? IMG_MARK : 32'h0000_0000;
    if (a[23:0] == 24'h000001) return 32'h0000_0002;
    return {6'h00, a};
  endfunction
  // Idle data inverts each idle cycle, so it alternates between the last word and its inverse
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend.delete();
      tog <= 1'b0;
      rsp <= '0;
    end else begin
      if (pend.size() > 0 && (!slow || tog)) begin
        rsp.valid <= 1'b1;
        rsp.data  <= word(pend.pop_front());
      end else begin
        rsp.valid <= 1'b0;
        rsp.data  <= ~rsp.data;
      end
      if (req.rd_req) pend.push_back(req.addr);
      tog <= ~tog;
    end
  end
endmodule

/* fbl_loader_tb.sv */
/*
  Self-checking testbench for the flash bitstream boot loader.
  Assumes the flash model and a small target model that is done after two words.
*/
`timescale 1ns/10ps
// ====================
// Testbench
// ====================
module fbl_loader_tb;
  import fbl_pkg::*;
  logic                clk_sys, rst_b, slow, clr_seen;
  logic [3:0]          mask;        // Sections holding an image
  fbl_pins_t           usr, pins;   // User pins, and pins with target lines added
  fbl_flash_req_t      flash_req;
  fbl_flash_rsp_t      flash_rsp;
  fbl_cfg_t            cfg_port;
  fbl_lamps_t          lamps;
  logic [1:0]          wr_cnt;      // Words since the last clear, held at two
  logic [CFG_W-1:0]    last_w[2];   // Two newest port words
  int                  err_count, cmp_count, wr_total, n;
  fbl_loader #(.BOOT_BUDGET_CYC(25'h00000c8), .DONE_WAIT_CYC(25'h0000032)) fbl_loader_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .pins_async(pins), .flash_req(flash_req),
    .flash_rsp(flash_rsp), .cfg_port(cfg_port), .lamps(lamps));
  fbl_flash_model fbl_flash_model_inst (.clk_sys(clk_sys), .rst_b(rst_b), .req(flash_req),
    .rsp(flash_rsp), .valid_mask(mask), .slow(slow));
  always #5 clk_sys = ~clk_sys;
  // Target: ready whenever not cleared, configured after two words
  always_comb begin
    pins = usr;
    pins.tgt_init_b = cfg_port.reload_button_b;
    pins.tgt_done = (wr_cnt == 2'h2);
  end
  always @(posedge clk_sys) begin
    if (!cfg_port.reload_button_b) begin
      wr_cnt <= 2'h0;
      clr_seen <= 1'b1;
    end else if (!cfg_port.wr_b) begin
      wr_cnt <= (wr_cnt == 2'h2) ? wr_cnt : wr_cnt + 2'h1;
      wr_total <= wr_total + 1;
      last_w[0] <= last_w[1];
      last_w[1] <= cfg_port.data;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  // Bounded wait for a load to start and finish
  task automatic wait_load();
    int k;
    k = 0;
    while (lamps.busy !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    k = 0;
    while (lamps.busy !== 1'b0 && k < 3000) begin
      tick(1);
      k++;
    end
    chk("loader idle", 32'h0, 32'(lamps.busy));
  endtask
  task automatic check_load(input logic [1:0] s, input logic fb);
    chk("section lamps", 32'(s), 32'({lamps.loaded_section_lamp1, lamps.loaded_section_lamp0}));
    chk("fallback lamp", 32'(fb), 32'(lamps.fallback_lamp));
    chk("error lamp", 32'h0, 32'(lamps.load_error_lamp));
    chk("done lamp", 32'h1, 32'(lamps.config_done_lamp));
    chk("budget lamp", 32'h0, 32'(lamps.budget_miss_lamp));
    chk("first word", {6'h00, s, 24'h000002}, last_w[0]);
    chk("second word", {6'h00, s, 24'h000003}, last_w[1]);
  endtask
  // Choice lines settle before the request rises and hold until the load ends
  task automatic request(input logic [2:0] c);
    {usr.image_choice_bit2_unused, usr.image_choice_bit1, usr.image_choice_bit0} = c;
    tick(2);
    usr.reload_request = 1'b1;
    wait_load();
    usr.reload_request = 1'b0;
    tick(8);
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100us;
    err_count++;
    conclude();
  end
  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    usr = '0;
    usr.boot_section_select = 2'h1;
    mask = 4'h7;
    slow = 1'b0;
    {err_count, cmp_count, wr_total, wr_cnt, clr_seen} = '0;
    tick(8);
    rst_b = 1'b1;
    wait_load();
    check_load(2'h1, 1'b0);
    for (int s = 0; s < 3; s++) begin
      request(3'({s[0], s[1:0]}));
      check_load(s[1:0], 1'b0);
    end
    slow = 1'b1;
    request(3'h3);
    check_load(2'h1, 1'b1);
    slow = 1'b0;
    // Jumper fitted: a request must leave the port alone
    usr.boot_mode_jumper = 1'b1;
    tick(10);
    n = wr_total;
    usr.reload_request = 1'b1;
    tick(40);
    chk("words while blocked", 32'(n), 32'(wr_total));
    chk("busy while blocked", 32'h0, 32'(lamps.busy));
    usr.reload_request = 1'b0;
    usr.boot_mode_jumper = 1'b0;
    tick(10);
    // Button: clear while held, reload from the boot section after release
    usr.reload_button = 1'b1;
    tick(40);
    chk("clear while held", 32'h0, 32'(cfg_port.reload_button_b));
    chk("lamps while held", 32'h0, 32'({lamps.loaded_section_lamp1, lamps.loaded_section_lamp0}));
    usr.reload_button = 1'b0;
    wait_load();
    check_load(2'h1, 1'b0);
    // Scan-port load takes the target over
    usr.scan_load_active = 1'b1;
    tick(20);
    chk("no clear in scan", 32'h1, 32'(cfg_port.reload_button_b));
    chk("lamps in scan", 32'h0, 32'({lamps.loaded_section_lamp1, lamps.loaded_section_lamp0}));
    usr.scan_load_active = 1'b0;
    tick(10);
    // Fresh power-up with an empty boot section
    usr.boot_section_select = 2'h3;
    rst_b = 1'b0;
    tick(8);
    clr_seen = 1'b0;
    rst_b = 1'b1;
    wait_load();
    chk("error lamp", 32'h1, 32'(lamps.load_error_lamp));
    chk("target cleared", 32'h0, 32'(clr_seen));
    conclude();
  end
endmodule
